// ==== rio_pkg.sv ====
// Shared constants and types for the RAM and I/O port block
package rio_pkg;

  // ----------------------------------------------------------------
  // Address map (byte offsets on the 8-bit bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_BIT_LIMIT = 8'h20;
  localparam logic [7:0] ADR_PORT_A    = 8'h20;
  localparam logic [7:0] ADR_PORT_B    = 8'h21;
  localparam logic [7:0] ADR_DIR_A     = 8'h22;
  localparam logic [7:0] ADR_DIR_B     = 8'h23;
  localparam logic [7:0] ADR_MODE      = 8'h24;
  localparam logic [7:0] ADR_RAM_BASE  = 8'h80;
  localparam int         RAM_DEPTH     = 128;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int BIT_VAL_POS  = 4;
  localparam int BIT_PORT_POS = 3;
  localparam int MODE_SEL_POS = 5;
  localparam int STRB_POS     = 7;
  localparam int FLAG_POS     = 6;
  localparam logic [7:0] RST_BYTE = 8'h00;

  typedef enum logic [1:0] {
    RIO_BASIC,
    RIO_STB_IN,
    RIO_STB_OUT,
    RIO_STB_TRI
  } rio_mode_t;

  typedef enum logic [2:0] {
    RIO_P_IDLE,
    RIO_P_SETUP,
    RIO_P_STRB,
    RIO_P_ACK,
    RIO_P_REL
  } rio_pstate_t;

  // Cycles the peripheral holds its strobe or acknowledge low
  localparam logic [1:0] PULSE_CYC = 2'h2;

endpackage : rio_pkg

// ==== rio_link_if.sv ====
// Port lines between the I/O block and the peripheral
`timescale 1ns/1ps
interface rio_link_if;
  logic [7:0] dev_pa_o;
  logic [7:0] dev_pa_oe;
  logic [7:0] dev_pb_o;
  logic [7:0] dev_pb_oe;
  logic [7:0] per_pa_o;
  logic [7:0] per_pa_oe;
  logic [7:0] per_pb_o;
  logic [7:0] per_pb_oe;
  logic [7:0] pa_lvl;
  logic [7:0] pb_lvl;

  // Undriven lines float high as if pulled up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pa_lvl[i] = dev_pa_oe[i] ? dev_pa_o[i]
                : (per_pa_oe[i] ? per_pa_o[i] : 1'b1);
      pb_lvl[i] = dev_pb_oe[i] ? dev_pb_o[i]
                : (per_pb_oe[i] ? per_pb_o[i] : 1'b1);
    end
  end

  modport device (
    input  pa_lvl, pb_lvl,
    output dev_pa_o, dev_pa_oe, dev_pb_o, dev_pb_oe
  );
  modport periph (
    input  pa_lvl, pb_lvl,
    output per_pa_o, per_pa_oe, per_pb_o, per_pb_oe
  );
endinterface : rio_link_if

// ==== rio_periph.sv ====
// Peripheral end: sends bytes by strobe, takes bytes by acknowledge
`timescale 1ns/1ps
module rio_periph (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  rio_link_if.periph      link,
  input  wire logic       out_dir_i,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_ready_o,
  output logic            rx_valid_o,
  output logic [7:0]      rx_data_o
);

  rio_pkg::rio_pstate_t st_ff;
  logic [1:0] cnt_ff;
  logic [7:0] data_ff;
  logic       drive_ff;
  logic       strb_ff;
  logic       tx_ready_ff;
  logic       rx_valid_ff;

  wire flag = link.pb_lvl[rio_pkg::FLAG_POS];

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_ff       <= rio_pkg::RIO_P_IDLE;
      cnt_ff      <= 2'h0;
      data_ff     <= rio_pkg::RST_BYTE;
      drive_ff    <= 1'b0;
      strb_ff     <= 1'b1;
      tx_ready_ff <= 1'b0;
      rx_valid_ff <= 1'b0;
    end else begin
      rx_valid_ff <= 1'b0;
      tx_ready_ff <= 1'b0;
      unique case (st_ff)
        rio_pkg::RIO_P_IDLE: begin
          if (!out_dir_i && tx_valid_i && !flag) begin
            data_ff     <= tx_data_i;
            drive_ff    <= 1'b1;
            tx_ready_ff <= 1'b1;
            st_ff       <= rio_pkg::RIO_P_SETUP;
          end else if (out_dir_i && !flag) begin
            strb_ff <= 1'b0;
            cnt_ff  <= 2'h0;
            st_ff   <= rio_pkg::RIO_P_ACK;
          end
        end
        rio_pkg::RIO_P_SETUP: begin
          // Data settles a cycle before the strobe falls
          strb_ff <= 1'b0;
          cnt_ff  <= 2'h0;
          st_ff   <= rio_pkg::RIO_P_STRB;
        end
        rio_pkg::RIO_P_STRB: begin
          cnt_ff <= cnt_ff + 2'h1;
          if (cnt_ff == rio_pkg::PULSE_CYC - 2'h1) begin
            strb_ff <= 1'b1;
            st_ff   <= rio_pkg::RIO_P_REL;
          end
        end
        rio_pkg::RIO_P_ACK: begin
          cnt_ff <= cnt_ff + 2'h1;
          // Tri-state port only drives after it sees acknowledge
          if (cnt_ff == rio_pkg::PULSE_CYC - 2'h1) begin
            data_ff     <= link.pa_lvl;
            rx_valid_ff <= 1'b1;
            strb_ff     <= 1'b1;
            st_ff       <= rio_pkg::RIO_P_REL;
          end
        end
        rio_pkg::RIO_P_REL: begin
          drive_ff <= 1'b0;
          if (out_dir_i ? flag : 1'b1)
            st_ff <= rio_pkg::RIO_P_IDLE;
        end
        default: st_ff <= rio_pkg::RIO_P_IDLE;
      endcase
    end
  end

  assign link.per_pa_o  = data_ff;
  assign link.per_pa_oe = {8{drive_ff}};
  assign link.per_pb_o  = {strb_ff, 7'h00};
  assign link.per_pb_oe = 8'h80;
  assign tx_ready_o     = tx_ready_ff;
  assign rx_valid_o     = rx_valid_ff;
  assign rx_data_o      = data_ff;

endmodule // rio_periph

// ==== rio_dev.sv ====
// Device end: 128-byte RAM and two 8-line ports with handshake
`timescale 1ns/1ps
module rio_dev (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  rio_link_if.device      link,
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  input  wire logic       wb_we_i,
  input  wire logic [7:0] wb_adr_i,
  input  wire logic [7:0] wb_dat_i,
  input  wire logic       wb_sel_i,
  output logic [7:0]      wb_dat_o,
  output logic            wb_ack_o,
  output logic            transfer_event_out_o
);

  logic [7:0] out_a_ff;
  logic [7:0] out_b_ff;
  logic [7:0] first_port_direction_ff;
  logic [7:0] second_port_direction_ff;
  logic [7:0] handshake_mode_select_ff;
  logic [7:0] in_latch_ff;
  logic       flag_ff;
  logic       event_ff;
  logic       strb_prev_ff;
  logic       ack_ff;
  logic [7:0] dat_ff;
  logic [7:0] pa_o_ff;
  logic [7:0] pa_oe_ff;
  logic [7:0] pb_o_ff;
  logic [7:0] pb_oe_ff;
  logic       evt_out_ff;
  logic [7:0] ram [rio_pkg::RAM_DEPTH];

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  rio_pkg::rio_mode_t mode;
  always_comb begin
    logic [2:0] m;
    m = handshake_mode_select_ff[rio_pkg::MODE_SEL_POS +: 3];
    if (!m[0])
      mode = rio_pkg::RIO_BASIC;
    else if (!m[1])
      mode = rio_pkg::RIO_STB_IN;
    else if (!m[2])
      mode = rio_pkg::RIO_STB_OUT;
    else
      mode = rio_pkg::RIO_STB_TRI;
  end

  wire hs      = (mode != rio_pkg::RIO_BASIC);
  wire hs_out  = (mode == rio_pkg::RIO_STB_OUT) ||
                 (mode == rio_pkg::RIO_STB_TRI);
  wire strb    = link.pb_lvl[rio_pkg::STRB_POS];
  wire strb_fall = strb_prev_ff && !strb;

  wire req     = wb_cyc_i && wb_stb_i && !ack_ff;
  wire wr      = req && wb_we_i && wb_sel_i;
  wire rd      = req && !wb_we_i;
  wire is_bit  = wb_adr_i < rio_pkg::ADR_BIT_LIMIT;
  wire is_ram  = wb_adr_i >= rio_pkg::ADR_RAM_BASE;
  wire bit_pb  = wb_adr_i[rio_pkg::BIT_PORT_POS];
  wire bit_val = wb_adr_i[rio_pkg::BIT_VAL_POS];
  wire [2:0] bit_idx = wb_adr_i[2:0];
  wire [6:0] ram_idx = wb_adr_i[6:0];
  wire byte_a  = wb_adr_i == rio_pkg::ADR_PORT_A;

  // Output lines read back their own latch value
  wire [7:0] view_a = (first_port_direction_ff & out_a_ff) |
                      (~first_port_direction_ff & link.pa_lvl);
  wire [7:0] view_b = (second_port_direction_ff & out_b_ff) |
                      (~second_port_direction_ff & link.pb_lvl);

  logic [7:0] rd_data;
  always_comb begin
    rd_data = rio_pkg::RST_BYTE;
    if (is_bit)
      rd_data = {(bit_pb ? view_b[bit_idx] : view_a[bit_idx]),
                 7'h00};
    else if (is_ram)
      rd_data = ram[ram_idx];
    else if (byte_a)
      rd_data = (mode == rio_pkg::RIO_STB_IN) ? in_latch_ff
                                              : view_a;
    else if (wb_adr_i == rio_pkg::ADR_PORT_B)
      rd_data = view_b;
    else if (wb_adr_i == rio_pkg::ADR_DIR_A)
      rd_data = first_port_direction_ff;
    else if (wb_adr_i == rio_pkg::ADR_DIR_B)
      rd_data = second_port_direction_ff;
    else if (wb_adr_i == rio_pkg::ADR_MODE)
      rd_data = handshake_mode_select_ff;
  end

  // ----------------------------------------------------------------
  // Bus answer: one wait state, unmapped reads return zero
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_ff <= 1'b0;
      dat_ff <= rio_pkg::RST_BYTE;
    end else begin
      ack_ff <= req;
      if (rd)
        dat_ff <= rd_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr && is_ram)
      ram[ram_idx] <= wb_dat_i;
  end

  // ----------------------------------------------------------------
  // Latches and configuration
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_a_ff                 <= rio_pkg::RST_BYTE;
      out_b_ff                 <= rio_pkg::RST_BYTE;
      first_port_direction_ff  <= rio_pkg::RST_BYTE;
      second_port_direction_ff <= rio_pkg::RST_BYTE;
      handshake_mode_select_ff <= rio_pkg::RST_BYTE;
    end else if (wr) begin
      if (is_bit) begin
        if (bit_pb)
          out_b_ff[bit_idx] <= bit_val;
        else
          out_a_ff[bit_idx] <= bit_val;
      end else begin
        unique case (wb_adr_i)
          rio_pkg::ADR_PORT_A: out_a_ff <= wb_dat_i;
          rio_pkg::ADR_PORT_B: out_b_ff <= wb_dat_i;
          rio_pkg::ADR_DIR_A:  first_port_direction_ff  <= wb_dat_i;
          rio_pkg::ADR_DIR_B:  second_port_direction_ff <= wb_dat_i;
          rio_pkg::ADR_MODE:   handshake_mode_select_ff <= wb_dat_i;
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Handshake: input latch, flag line and transfer event
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i)
      strb_prev_ff <= 1'b1;
    else
      strb_prev_ff <= strb;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i)
      in_latch_ff <= rio_pkg::RST_BYTE;
    else if (mode == rio_pkg::RIO_STB_IN && strb_fall)
      in_latch_ff <= link.pa_lvl;
  end

  // Hardware events beat the clearing access in the same cycle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flag_ff <= 1'b0;
    end else if (wr && wb_adr_i == rio_pkg::ADR_MODE) begin
      // Output modes idle with data-ready high
      flag_ff <= wb_dat_i[rio_pkg::MODE_SEL_POS] &
                 wb_dat_i[rio_pkg::MODE_SEL_POS + 1];
    end else if (mode == rio_pkg::RIO_STB_IN) begin
      if (strb_fall)
        flag_ff <= 1'b1;
      else if (rd && byte_a)
        flag_ff <= 1'b0;
    end else if (hs_out) begin
      if (!strb)
        flag_ff <= 1'b1;
      else if (wr && byte_a)
        flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      event_ff <= 1'b0;
    end else if (!hs) begin
      event_ff <= 1'b0;
    end else if (mode == rio_pkg::RIO_STB_IN) begin
      if (strb_fall)
        event_ff <= 1'b1;
      else if (rd && byte_a)
        event_ff <= 1'b0;
    end else begin
      if (!strb && !flag_ff)
        event_ff <= 1'b1;
      else if (wr && byte_a)
        event_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers, all registered
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pa_o_ff    <= rio_pkg::RST_BYTE;
      pa_oe_ff   <= rio_pkg::RST_BYTE;
      pb_o_ff    <= rio_pkg::RST_BYTE;
      pb_oe_ff   <= rio_pkg::RST_BYTE;
      evt_out_ff <= 1'b0;
    end else begin
      pa_o_ff  <= out_a_ff;
      pa_oe_ff <= (mode == rio_pkg::RIO_STB_TRI && strb)
                  ? rio_pkg::RST_BYTE
                  : first_port_direction_ff;
      pb_o_ff  <= out_b_ff;
      if (hs)
        pb_o_ff[rio_pkg::FLAG_POS] <= flag_ff;
      // Strobe line relies on software leaving it an input
      pb_oe_ff   <= second_port_direction_ff;
      evt_out_ff <= event_ff & out_b_ff[rio_pkg::STRB_POS];
    end
  end

  assign link.dev_pa_o  = pa_o_ff;
  assign link.dev_pa_oe = pa_oe_ff;
  assign link.dev_pb_o  = pb_o_ff;
  assign link.dev_pb_oe = pb_oe_ff;
  assign wb_dat_o             = dat_ff;
  assign wb_ack_o             = ack_ff;
  assign transfer_event_out_o = evt_out_ff;

endmodule // rio_dev

// ==== rio_link_props.sv ====
// Checker on the port lines joining the device and peripheral ends
`timescale 1ns/1ps
module rio_link_props (
  input wire logic       clk_i,
  input wire logic       resetn_i,
  input wire logic [7:0] dev_pa_o,
  input wire logic [7:0] dev_pa_oe,
  input wire logic [7:0] dev_pb_oe,
  input wire logic [7:0] per_pa_oe,
  input wire logic [7:0] per_pb_oe,
  input wire logic [7:0] pb_lvl
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  // Low pulse on the strobe line, two edges low as the device sees it
  sequence s_low;
    pb_lvl[7] ##1 !pb_lvl[7] [*2];
  endsequence

  a_reset_idle: assert property (
    $rose(resetn_i) |-> dev_pa_oe == 8'h00 && dev_pb_oe == 8'h00)
    else $error("port lines driven after reset");
  a_low_flag: assert property (
    dev_pb_oe[6] ##0 s_low |-> ##[1:4] pb_lvl[6])
    else $error("flag not high after strobe or acknowledge");
  a_ack_drive: assert property (
    s_low ##0 per_pa_oe == 8'h00 |-> ##[0:3] dev_pa_oe != 8'h00)
    else $error("port A not driven during acknowledge");
  a_flag_falls: assert property (
    $fell(pb_lvl[6]) |-> pb_lvl[7])
    else $error("flag fell while strobe line low");
  a_fall_dir: assert property (
    $fell(pb_lvl[6]) |-> dev_pb_oe[6])
    else $error("flag line low without output direction");
  a_pa_clash: assert property (
    (dev_pa_oe & per_pa_oe) == 8'h00)
    else $error("both ends drive port A");
  a_pb_clash: assert property (
    (dev_pb_oe & per_pb_oe) == 8'h00)
    else $error("both ends drive port B");
  // Held data must not move while the far end is taking it
  a_ack_stable: assert property (
    !pb_lvl[7] && !$past(pb_lvl[7]) && per_pa_oe == 8'h00
    && dev_pa_oe != 8'h00 && $past(dev_pa_oe) != 8'h00
    |-> $stable(dev_pa_o))
    else $error("port A data changed during acknowledge");
endmodule // rio_link_props

// ==== ram_io_port_handshake_tb.sv ====
// Self-checking bench joining the device and peripheral ends
`timescale 1ns/1ps
module ram_io_port_handshake_tb;
  logic       clk_i;
  logic       resetn_i;
  logic       wb_cyc;
  logic       wb_stb;
  logic       wb_we;
  logic       wb_sel;
  logic [7:0] wb_adr;
  logic [7:0] wb_dat;
  logic [7:0] wb_q;
  logic       wb_ack;
  logic       evt;
  logic       out_dir;
  logic       tx_valid;
  logic [7:0] tx_data;
  logic       tx_ready;
  logic       rx_valid;
  logic [7:0] rx_data;
  logic [7:0] rd;
  int         n_mismatch;
  int         n_tests;

  rio_link_if link ();
  rio_dev rio_dev_inst (.clk_i(clk_i), .resetn_i(resetn_i),
    .link(link.device), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat),
    .wb_sel_i(wb_sel), .wb_dat_o(wb_q), .wb_ack_o(wb_ack),
    .transfer_event_out_o(evt));
  rio_periph rio_periph_inst (.clk_i(clk_i), .resetn_i(resetn_i),
    .link(link.periph), .out_dir_i(out_dir), .tx_valid_i(tx_valid),
    .tx_data_i(tx_data), .tx_ready_o(tx_ready),
    .rx_valid_o(rx_valid), .rx_data_o(rx_data));
  rio_link_props rio_link_props_inst (.clk_i(clk_i),
    .resetn_i(resetn_i), .dev_pa_o(link.dev_pa_o),
    .dev_pa_oe(link.dev_pa_oe), .dev_pb_oe(link.dev_pb_oe),
    .per_pa_oe(link.per_pa_oe), .per_pb_oe(link.per_pb_oe),
    .pb_lvl(link.pb_lvl));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  // Classic cycle; request holds until ack is seen at a rising edge
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [7:0] d);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_sel <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= d;
    do
      @(posedge clk_i);
    while (wb_ack !== 1'b1);
    rd = wb_q;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(rd, e);
  endtask

  // Pins lag register state by one edge; never judge in the launch step
  task automatic wait_flag(input logic v);
    @(negedge clk_i);
    for (int k = 0; k < 30 && link.pb_lvl[6] !== v; k++) @(negedge clk_i);
    chk({7'h00, link.pb_lvl[6]}, {7'h00, v});
  endtask

  task automatic send(input logic [7:0] d);
    @(posedge clk_i);
    tx_data <= d;
    tx_valid <= 1'b1;
    for (int k = 0; k < 30 && tx_ready !== 1'b1; k++) @(posedge clk_i);
    chk({7'h00, tx_ready}, 8'h01);
    tx_valid <= 1'b0;
  endtask

  task automatic take(input logic [7:0] d);
    for (int k = 0; k < 40 && rx_valid !== 1'b1; k++) @(negedge clk_i);
    chk(rx_data, d);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rdc(8'h22, 8'h00);
    rdc(8'h23, 8'h00);
    rdc(8'h24, 8'h00);
    rdc(8'h20, 8'hFF);
    rdc(8'h30, 8'h00);
  endtask

  task automatic t_bits;
    wr(8'h22, 8'hFF);
    @(negedge clk_i);
    chk(link.pa_lvl, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr({3'h0, ~i[0], 1'b0, i[2:0]}, 8'h00);
    end
    @(negedge clk_i);
    chk(link.pa_lvl, 8'h55);
    for (int i = 0; i < 8; i++) begin
      rdc({5'h00, i[2:0]}, {~i[0], 7'h00});
    end
    wr(8'h20, 8'hA6);
    @(negedge clk_i);
    chk(link.pa_lvl, 8'hA6);
    rdc(8'h20, 8'hA6);
    rdc(8'h1F, 8'h80);
    wr(8'h23, 8'h01);
    wr(8'h18, 8'h00);
    rdc(8'h08, 8'h80);
    wr(8'h08, 8'hFF);
    rdc(8'h21, 8'hFE);
    wr(8'h80, 8'h5A);
    wr(8'hFF, 8'hA5);
    rdc(8'h80, 8'h5A);
    rdc(8'hFF, 8'hA5);
  endtask

  task automatic t_in;
    wr(8'h22, 8'h00);
    wr(8'h23, 8'h40);
    wr(8'h24, 8'h3F);
    wr(8'h1F, 8'h00);
    send(8'h3C);
    wait_flag(1'b1);
    chk({7'h00, evt}, 8'h01);
    rdc(8'h20, 8'h3C);
    wait_flag(1'b0);
    chk({7'h00, evt}, 8'h00);
    wr(8'h0F, 8'h00);
    send(8'hC3);
    wait_flag(1'b1);
    chk({7'h00, evt}, 8'h00);
    rdc(8'h20, 8'hC3);
    wait_flag(1'b0);
  endtask

  // Far end only starts receiving once the port A write has cleared the flag
  task automatic t_out(input logic [7:0] m);
    wr(8'h24, m);
    @(posedge clk_i);
    out_dir <= 1'b1;
    @(negedge clk_i);
    chk(link.dev_pa_oe, m[7] ? 8'h00 : 8'hFF);
    wr(8'h20, 8'h96);
    take(8'h96);
    wait_flag(1'b1);
    chk({7'h00, evt}, 8'h01);
    chk(link.dev_pa_oe, m[7] ? 8'h00 : 8'hFF);
    wr(8'h20, 8'h69);
    @(negedge clk_i);
    chk({7'h00, evt}, 8'h00);
    take(8'h69);
    wait_flag(1'b1);
  endtask

  task automatic summarize;
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    resetn_i = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_sel = 1'b0;
    wb_adr = 8'h00;
    wb_dat = 8'h00;
    out_dir = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    n_mismatch = 0;
    n_tests = 0;
    repeat (6) @(negedge clk_i);
    chk(link.dev_pa_oe | link.dev_pb_oe, 8'h00);
    @(posedge clk_i);
    resetn_i <= 1'b1;
    t_reset();
    t_bits();
    t_in();
    wr(8'h1F, 8'h00);
    wr(8'h22, 8'hFF);
    t_out(8'h7F);
    t_out(8'hE0);
    @(posedge clk_i);
    out_dir <= 1'b0;
    wr(8'h24, 8'hDE);
    // Event clears an edge after the mode, its pin one edge later
    repeat (2) @(negedge clk_i);
    chk({7'h00, evt}, 8'h00);
    chk(link.dev_pa_oe, 8'hFF);
    summarize();
  end

  initial begin
    #(25.0 * 20000);
    n_mismatch++;
    summarize();
  end
endmodule // ram_io_port_handshake_tb
